// ### core/dsb_sram_port.sv
`timescale 1ns/1ps

// ----------------------------------------
// Toggle event crossing into the system clock
// ----------------------------------------
module dsb_tog_sync (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tog_i,
    output logic pulse_o
);
    logic [2:0] s_q;
    logic last_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= 3'h0;
            last_q <= 1'b0;
        end else begin
            s_q <= {s_q[1:0], tog_i};
            if (s_q[1] == s_q[2]) begin
                last_q <= s_q[2];
            end
        end
    end

    // Only the agreeing later stages are looked at
    assign pulse_o = (s_q[1] == s_q[2]) && (s_q[2] != last_q);
endmodule // dsb_tog_sync

// How it works
// RULE1: Inputs sampled only on rising edges of the capture pair (rise/fall of cap_clk_i).
// RULE2: Separate dedicated read output bus and write input bus; no bus turnaround.
// RULE3: One shared address bus; each load routed to read or write port.
// RULE4: Read and write addresses latched on rising capture edges, may alternate each cycle.
// RULE5: Write words captured on negative then positive capture edge, one each.
// RULE6: Each location holds two 18-bit words moved as a two-word burst.
// RULE7: Read words launched from output registers on rising edges of the capture pair.
// RULE8: Bypass pin high: first read word appears 1.5 cycles after address.
// RULE9: Bypass pin low: first read word appears 1 cycle after address.
// RULE10: Every synchronous input is registered on a capture edge before use.
// RULE11: Echo strobe pair driven in step with the read data launch edges.
// RULE12: Writes commit internally with no write pulse from the controller.
// RULE13: Load low starts a cycle; direction high reads, low writes.
// RULE14: Active-low masks per word: mask0 bits 8..0, mask1 bits 17..9.
// RULE15: Read output bus released (enable low) whenever no read word is driven.
// RULE16: 22-bit word index decoded on rising edge; ignored without a load.
// RULE17: Controller issues one load per cycle, write words in burst order.
// RULE18: Controller keeps bypass pin static and matches its capture delay.
module dsb_sram_port #(
    parameter int DEPTH_W = dsb_pkg::ADDR_W
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cap_clk_i,
    input wire logic load_strobe_n_i,
    input wire logic dir_select_i,
    input wire logic [dsb_pkg::ADDR_W-1:0] memory_word_index_i,
    input wire logic [dsb_pkg::WORD_W-1:0] write_input_bus_i,
    input wire logic [dsb_pkg::LANES-1:0] byte_write_mask_n_i,
    input wire logic pll_bypass_n_i,
    output logic [dsb_pkg::WORD_W-1:0] read_output_bus_o,
    output logic read_output_oe_o,
    output logic echo_strobe_o,
    output logic echo_strobe_n_o,
    output logic [dsb_pkg::CNT_W-1:0] read_count_o,
    output logic [dsb_pkg::CNT_W-1:0] write_count_o
);
    localparam int W = dsb_pkg::WORD_W;
    localparam int LW = dsb_pkg::LANE_W;

    logic [1:0] krst_q;
    logic krst_n;
    dsb_pkg::dsb_cmd_t cmd_q;
    dsb_pkg::dsb_beat_t beat_p_q;
    dsb_pkg::dsb_beat_t beat_n_q;
    dsb_pkg::dsb_beat_t w0_q;
    logic [dsb_pkg::SYNC_STAGES-1:0] strap_q;
    logic lat15_q;
    logic wp_q;
    logic [DEPTH_W-1:0] wa_q;
    logic [2*W-1:0] mem_q [2**DEPTH_W];
    logic [2*W-1:0] rd_word;
    logic [2*W-1:0] rd_q;
    logic rv_q;
    logic [W-1:0] q_p_q;
    logic [W-1:0] q_n_q;
    logic oe_p_q;
    logic oe_n_q;
    logic tp_q;
    logic tn_q;
    logic rd_tog_q;
    logic wr_tog_q;
    logic rd_evt;
    logic wr_evt;
    logic [dsb_pkg::CNT_W-1:0] rd_cnt_q;
    logic [dsb_pkg::CNT_W-1:0] wr_cnt_q;

    // ----------------------------------------
    // Link reset: asserts at once, releases on the link clock
    // ----------------------------------------
    always_ff @(posedge cap_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            krst_q <= 2'h0;
        end else begin
            krst_q <= {krst_q[0], 1'b1};
        end
    end
    assign krst_n = krst_q[1];

    // ----------------------------------------
    // Input registers
    // ----------------------------------------
    // The negative capture clock is taken as the complement of cap_clk_i,
    // so its rising edge is the falling edge of cap_clk_i.
    always_ff @(posedge cap_clk_i or negedge krst_n) begin
        if (!krst_n) begin
            cmd_q <= '0;
            beat_p_q <= '0;
        end else begin
            cmd_q.load <= ~load_strobe_n_i; // [RULE1] [RULE10] [RULE13]
            cmd_q.read <= dir_select_i; // [RULE13]
            cmd_q.addr <= memory_word_index_i; // [RULE3] [RULE4] [RULE16]
            beat_p_q <= {write_input_bus_i, byte_write_mask_n_i}; // [RULE5] [RULE14]
        end
    end

    always_ff @(negedge cap_clk_i or negedge krst_n) begin
        if (!krst_n) begin
            beat_n_q <= '0;
        end else begin
            beat_n_q <= {write_input_bus_i, byte_write_mask_n_i}; // [RULE1] [RULE5] [RULE10]
        end
    end

    // ----------------------------------------
    // Latency strap
    // ----------------------------------------
    // Static pin; a change is taken only once two late stages agree
    always_ff @(posedge cap_clk_i or negedge krst_n) begin
        if (!krst_n) begin
            // Preset to the assumed strap so no false agreement flips the mode
            strap_q <= {dsb_pkg::SYNC_STAGES{dsb_pkg::LAT15_RST}};
            lat15_q <= dsb_pkg::LAT15_RST;
        end else begin
            strap_q <= {strap_q[1:0], pll_bypass_n_i};
            if (strap_q[1] == strap_q[2]) begin
                lat15_q <= strap_q[2]; // [RULE8] [RULE9]
            end
        end
    end

    // ----------------------------------------
    // Write port
    // ----------------------------------------
    always_ff @(posedge cap_clk_i or negedge krst_n) begin
        if (!krst_n) begin
            wp_q <= 1'b0;
            wa_q <= '0;
            w0_q <= '0;
        end else begin
            wp_q <= cmd_q.load & ~cmd_q.read; // [RULE3] [RULE13] [RULE16]
            wa_q <= cmd_q.addr[DEPTH_W-1:0];
            w0_q <= beat_n_q; // Saved before the next negative edge overwrites it
        end
    end

    // Commit once the second word is registered; no external write pulse
    always_ff @(posedge cap_clk_i) begin
        if (wp_q) begin // [RULE12]
            for (int l = 0; l < dsb_pkg::LANES; l++) begin
                if (!w0_q.mask_n[l]) begin // [RULE14]
                    mem_q[wa_q][l*LW +: LW] <= w0_q.data[l*LW +: LW]; // [RULE6]
                end
                if (!beat_p_q.mask_n[l]) begin // [RULE14]
                    mem_q[wa_q][W + l*LW +: LW] <= beat_p_q.data[l*LW +: LW]; // [RULE6]
                end
            end
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    // No forwarding: a read just behind a write to the same word sees old data
    assign rd_word = mem_q[cmd_q.addr[DEPTH_W-1:0]];

    always_ff @(posedge cap_clk_i or negedge krst_n) begin
        if (!krst_n) begin
            rv_q <= 1'b0;
            rd_q <= '0;
        end else begin
            rv_q <= cmd_q.load & cmd_q.read; // [RULE3] [RULE16]
            rd_q <= rd_word; // [RULE6]
        end
    end

    always_ff @(posedge cap_clk_i or negedge krst_n) begin
        if (!krst_n) begin
            q_p_q <= dsb_pkg::WORD_RST;
            oe_p_q <= 1'b0;
        end else if (!lat15_q) begin
            q_p_q <= rd_word[W-1:0]; // [RULE7] [RULE9]
            oe_p_q <= cmd_q.load & cmd_q.read; // [RULE15]
        end else begin
            q_p_q <= rd_q[2*W-1:W]; // [RULE7] [RULE8]
            oe_p_q <= rv_q; // [RULE15]
        end
    end

    always_ff @(negedge cap_clk_i or negedge krst_n) begin
        if (!krst_n) begin
            q_n_q <= dsb_pkg::WORD_RST;
            oe_n_q <= 1'b0;
        end else begin
            q_n_q <= lat15_q ? rd_q[W-1:0] : rd_q[2*W-1:W]; // [RULE7] [RULE8] [RULE9]
            oe_n_q <= rv_q; // [RULE15]
        end
    end

    // ----------------------------------------
    // Echo strobes
    // ----------------------------------------
    // Two toggles, one per edge, so the echo follows the same launch edges
    always_ff @(posedge cap_clk_i or negedge krst_n) begin
        if (!krst_n) begin
            tp_q <= 1'b0;
        end else begin
            tp_q <= ~tp_q; // [RULE11]
        end
    end

    always_ff @(negedge cap_clk_i or negedge krst_n) begin
        if (!krst_n) begin
            tn_q <= 1'b0;
        end else begin
            tn_q <= tp_q; // [RULE11]
        end
    end

    // Double-rate launch: the half-cycle selector is the only logic after the data and enable flops; the echo is an XOR of the two toggles
    assign read_output_bus_o = cap_clk_i ? q_p_q : q_n_q; // [RULE2] [RULE7]
    assign read_output_oe_o = cap_clk_i ? oe_p_q : oe_n_q; // [RULE15]
    assign echo_strobe_o = tp_q ^ tn_q; // [RULE11]
    assign echo_strobe_n_o = ~(tp_q ^ tn_q);

    // ----------------------------------------
    // Activity counters on the system clock
    // ----------------------------------------
    always_ff @(posedge cap_clk_i or negedge krst_n) begin
        if (!krst_n) begin
            rd_tog_q <= 1'b0;
            wr_tog_q <= 1'b0;
        end else begin
            rd_tog_q <= rd_tog_q ^ (cmd_q.load & cmd_q.read);
            wr_tog_q <= wr_tog_q ^ wp_q;
        end
    end

    dsb_tog_sync u_rd_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .tog_i(rd_tog_q),
        .pulse_o(rd_evt)
    );

    dsb_tog_sync u_wr_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .tog_i(wr_tog_q),
        .pulse_o(wr_evt)
    );

    // Counters wrap; one event per link burst, bursts closer than the
    // crossing can resolve cancel in pairs, as their toggles undo each other
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_cnt_q <= dsb_pkg::CNT_RST;
            wr_cnt_q <= dsb_pkg::CNT_RST;
        end else begin
            rd_cnt_q <= rd_cnt_q + dsb_pkg::CNT_W'(rd_evt);
            wr_cnt_q <= wr_cnt_q + dsb_pkg::CNT_W'(wr_evt);
        end
    end
    assign read_count_o = rd_cnt_q;
    assign write_count_o = wr_cnt_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_lat1_first;
        @(posedge cap_clk_i) disable iff (!krst_n)
        (cmd_q.load && cmd_q.read && !lat15_q) |=> oe_p_q && (q_p_q == $past(rd_word[W-1:0]));
    endproperty
    a_lat1_first: assert property (p_lat1_first) else $error("1-cycle read word late"); // [RULE9]

    property p_lat15_first;
        @(posedge cap_clk_i) disable iff (!krst_n)
        (cmd_q.load && cmd_q.read && lat15_q) |=> !oe_p_q && oe_n_q ##1 oe_p_q;
    endproperty
    a_lat15_first: assert property (p_lat15_first) else $error("1.5-cycle read timing"); // [RULE8]

    property p_release;
        @(posedge cap_clk_i) disable iff (!krst_n)
        (!cmd_q.load ##1 (!rv_q && !cmd_q.load)) |=> !oe_p_q;
    endproperty
    a_release: assert property (p_release) else $error("Read bus driven idle"); // [RULE15]

    property p_neg_word;
        @(negedge cap_clk_i) disable iff (!krst_n)
        rv_q |=> oe_n_q && (q_n_q == (lat15_q ? $past(rd_q[W-1:0]) : $past(rd_q[2*W-1:W])));
    endproperty
    a_neg_word: assert property (p_neg_word) else $error("Second edge word wrong"); // [RULE6]

    property p_wr_route;
        @(posedge cap_clk_i) disable iff (!krst_n)
        (cmd_q.load && !cmd_q.read) |=> wp_q && !rv_q && (wa_q == $past(cmd_q.addr[DEPTH_W-1:0]));
    endproperty
    a_wr_route: assert property (p_wr_route) else $error("Write not routed"); // [RULE3]

    property p_ignore;
        @(posedge cap_clk_i) disable iff (!krst_n)
        !cmd_q.load |=> !wp_q && !rv_q;
    endproperty
    a_ignore: assert property (p_ignore) else $error("Index used without load"); // [RULE16]

    property p_load_in;
        @(posedge cap_clk_i) disable iff (!krst_n)
        !load_strobe_n_i && dir_select_i |=> cmd_q.load && cmd_q.read ##1 rv_q;
    endproperty
    a_load_in: assert property (p_load_in) else $error("Read load lost"); // [RULE13]

    property p_mask_word0;
        @(posedge cap_clk_i) disable iff (!krst_n)
        (cmd_q.load && !cmd_q.read) |=> (w0_q == $past(beat_n_q));
    endproperty
    a_mask_word0: assert property (p_mask_word0) else $error("First write beat lost"); // [RULE14]

    property p_echo_rise;
        @(posedge cap_clk_i) disable iff (!krst_n)
        $past(krst_n) |-> !echo_strobe_o;
    endproperty
    a_echo_rise: assert property (p_echo_rise) else $error("Echo out of step"); // [RULE11]

    c_read_lat1: cover property (@(posedge cap_clk_i) disable iff (!krst_n)
        cmd_q.load && cmd_q.read && !lat15_q ##1 oe_p_q);
    c_read_lat15: cover property (@(posedge cap_clk_i) disable iff (!krst_n)
        cmd_q.load && cmd_q.read && lat15_q ##2 oe_p_q);
    c_masked_write: cover property (@(posedge cap_clk_i) disable iff (!krst_n)
        wp_q && (beat_p_q.mask_n != 2'h0));
    c_read_then_write: cover property (@(posedge cap_clk_i) disable iff (!krst_n)
        cmd_q.load && cmd_q.read ##1 cmd_q.load && !cmd_q.read);
endmodule // dsb_sram_port

// ### inc/dsb_pkg.sv
// ----------------------------------------
// Shared constants and carriers
// ----------------------------------------
package dsb_pkg;
    localparam int ADDR_W = 22;
    localparam int WORD_W = 18;
    localparam int LANE_W = 9;
    localparam int LANES = 2;
    localparam int CNT_W = 16;
    localparam int SYNC_STAGES = 3;
    localparam logic [WORD_W-1:0] WORD_RST = 18'h00000;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    // Strap value assumed before the pin has settled: the 1.5-cycle mode
    localparam logic LAT15_RST = 1'b1;
    // Read data is launched this many link half-cycles after the address edge
    localparam int LAT1_HALF_CYCLES = 2;
    localparam int LAT15_HALF_CYCLES = 3;

    typedef struct packed {
        logic load;
        logic read;
        logic [ADDR_W-1:0] addr;
    } dsb_cmd_t;

    typedef struct packed {
        logic [WORD_W-1:0] data;
        logic [LANES-1:0] mask_n;
    } dsb_beat_t;
endpackage

// ### verif/dsb_ctl_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Controller model on the link side
// ----------------------------------------
module dsb_ctl_model (
    input wire logic cap_clk_i,
    output logic load_strobe_n_o,
    output logic dir_select_o,
    output logic [dsb_pkg::ADDR_W-1:0] addr_o,
    output logic [dsb_pkg::WORD_W-1:0] wdata_o,
    output logic [dsb_pkg::LANES-1:0] mask_n_o,
    input wire logic [dsb_pkg::WORD_W-1:0] rdata_i,
    input wire logic rdata_oe_i
);
    initial begin
        load_strobe_n_o = 1'b1;
        dir_select_o = 1'b0;
        addr_o = '0;
        wdata_o = '0;
        mask_n_o = 2'h3;
    end

    // Released command lines toggle so a stale value can never pass for a real one;
    // write lines are left to the burst that owns them
    task automatic idle();
        @(posedge cap_clk_i);
        load_strobe_n_o <= 1'b1;
        dir_select_o <= ~dir_select_o;
        addr_o <= ~addr_o;
    endtask

    task automatic wr(input logic ld_n, input logic [dsb_pkg::ADDR_W-1:0] a,
                      input logic [17:0] w0, input logic [17:0] w1,
                      input logic [1:0] m0, input logic [1:0] m1);
        @(posedge cap_clk_i);
        load_strobe_n_o <= ld_n;
        dir_select_o <= 1'b0;
        addr_o <= a;
        // Words follow the command edge, so the next load may go out meanwhile
        fork
            begin
                @(posedge cap_clk_i);
                wdata_o <= w0;
                mask_n_o <= m0;
                @(negedge cap_clk_i);
                wdata_o <= w1;
                mask_n_o <= m1;
            end
        join_none
    endtask

    // Samples seven half-cycles a quarter period after each edge
    task automatic rd(input logic [dsb_pkg::ADDR_W-1:0] a,
                      output logic [7:1][17:0] q, output logic [7:1] oe);
        @(posedge cap_clk_i);
        load_strobe_n_o <= 1'b0;
        dir_select_o <= 1'b1;
        addr_o <= a;
        for (int k = 1; k <= 7; k++) begin
            @(cap_clk_i);
            if (k == 2) begin
                load_strobe_n_o <= 1'b1;
                addr_o <= ~addr_o;
                dir_select_o <= 1'b0;
            end
            #3.75;
            q[k] = rdata_i;
            oe[k] = rdata_oe_i;
        end
    endtask
endmodule // dsb_ctl_model

// ### verif/test_ddr_sio_sram_burst2_port.sv
`timescale 1ns/1ps

module test_ddr_sio_sram_burst2_port;
    logic clk_i = 1'b0;
    logic cap_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic strap = 1'b1;
    logic ld_n, dir, oe, echo, echo_n;
    logic [21:0] addr;
    logic [17:0] wdat, rdat;
    logic [1:0] mask;
    logic [15:0] rcnt, wcnt;
    logic [7:1][17:0] q;
    logic [7:1] qoe;
    int bad_count = 0;
    int n_compared = 0;
    int n_rd = 0;
    int n_wr = 0;

    always #12.5 clk_i = ~clk_i;
    initial begin
        #3.3;
        forever #7.5 cap_clk_i = ~cap_clk_i;
    end

    dsb_sram_port #(.DEPTH_W(8)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .cap_clk_i(cap_clk_i),
        .load_strobe_n_i(ld_n), .dir_select_i(dir), .memory_word_index_i(addr),
        .write_input_bus_i(wdat), .byte_write_mask_n_i(mask), .pll_bypass_n_i(strap),
        .read_output_bus_o(rdat), .read_output_oe_o(oe), .echo_strobe_o(echo),
        .echo_strobe_n_o(echo_n), .read_count_o(rcnt), .write_count_o(wcnt));
    dsb_ctl_model u_ctl (.cap_clk_i(cap_clk_i), .load_strobe_n_o(ld_n), .dir_select_o(dir),
        .addr_o(addr), .wdata_o(wdat), .mask_n_o(mask), .rdata_i(rdat), .rdata_oe_i(oe));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Strap only moves while reset is held, so it is static in operation
    task automatic do_reset(input logic m);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        strap <= m;
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        n_rd = 0;
        n_wr = 0;
        repeat (6) u_ctl.idle();
    endtask

    task automatic wr(input logic [21:0] a, input logic [17:0] w0, input logic [17:0] w1,
                      input logic [1:0] m);
        u_ctl.wr(1'b0, a, w0, w1, m, m);
        n_wr++;
        // Spacing lets each commit cross to the slower counter clock on its own
        repeat (3) u_ctl.idle();
    endtask

    task automatic rdchk(input logic [21:0] a, input logic [17:0] e0, input logic [17:0] e1);
        int f;
        f = strap ? 5 : 4;
        u_ctl.rd(a, q, qoe);
        n_rd++;
        chk(q[f], e0, "word0");
        chk(q[f+1], e1, "word1");
        chk({11'h000, qoe}, {11'h000, (strap ? 7'h30 : 7'h18)}, "oe");
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_idle();
        repeat (4) begin
            @(cap_clk_i);
            #3.75;
            chk({15'h0000, oe, echo, echo_n}, {15'h0000, 1'b0, cap_clk_i, ~cap_clk_i}, "echo");
        end
        $display("done idle echo");
    endtask

    task automatic t_mask();
        logic [17:0] e;
        for (int m = 0; m < 4; m++) begin
            wr(22'h000034, 18'h3ffff, 18'h3ffff, 2'h0);
            wr(22'h000034, 18'h00000, 18'h00000, m[1:0]);
            e = {(m[1] ? 9'h1ff : 9'h000), (m[0] ? 9'h1ff : 9'h000)};
            rdchk(22'h000034, e, e);
        end
        $display("done masks");
    endtask

    task automatic t_ghost();
        wr(22'h000056, 18'h11111, 18'h22222, 2'h0);
        u_ctl.wr(1'b1, 22'h000056, 18'h3cccc, 18'h03333, 2'h0, 2'h0);
        u_ctl.idle();
        rdchk(22'h000056, 18'h11111, 18'h22222);
        $display("done no-load");
    endtask

    // Read loaded right after a write to the same word sees the old data
    task automatic t_b2b();
        wr(22'h000078, 18'h2a5a5, 18'h15a5a, 2'h0);
        u_ctl.wr(1'b0, 22'h000078, 18'h30f0f, 18'h0f0f0, 2'h0, 2'h0);
        n_wr++;
        rdchk(22'h000078, 18'h2a5a5, 18'h15a5a);
        rdchk(22'h000078, 18'h30f0f, 18'h0f0f0);
        $display("done back-to-back");
    endtask

    task automatic run_all();
        t_idle();
        t_mask();
        t_ghost();
        t_b2b();
        repeat (12) @(posedge clk_i);
        chk({2'h0, wcnt}, 18'(n_wr), "writes");
        chk({2'h0, rcnt}, 18'(n_rd), "reads");
        $display("done mode %0d", strap);
    endtask

    initial begin
        #200000;
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        finish_test();
    end

    initial begin
        do_reset(1'b1);
        run_all();
        do_reset(1'b0);
        run_all();
        finish_test();
    end
endmodule // test_ddr_sio_sram_burst2_port
